// >>> sram_dev_model.sv
`timescale 1ns/1ps
module sram_dev_model
    import sram_host_pkg::*;
#(
    parameter int ACC_NS = 30
) (
    input  wire logic [ADDR_W-1:0] address_lines,
    input  wire logic              chip_sel_n,
    input  wire logic              write_strobe_n,
    input  wire logic              out_drive_n,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out
);
    logic [DATA_W-1:0] cells [logic [ADDR_W-1:0]];
    logic [DATA_W-1:0] rd_val;
    logic [DATA_W-1:0] rd_late;
    logic [DATA_W-1:0] last_val = 4'h0;
    logic              drive;
    logic              wr_on;
    logic              wr_was = 1'b0;
    assign wr_on = !chip_sel_n && !write_strobe_n;
    // Word latched as the write interval closes, free of same-step pin races
    always @(address_lines, wr_on) begin
        if (wr_was && !wr_on) cells[address_lines] = data_in;
        wr_was = wr_on;
        rd_val = cells.exists(address_lines) ? cells[address_lines] : 'x;
    end
    assign #ACC_NS rd_late = rd_val;
    assign drive = !chip_sel_n && write_strobe_n && !out_drive_n;
    // Released lines show the inverse of the last word
    always @(rd_late, drive) begin
        if (drive) last_val = rd_late;
        data_out = drive ? rd_late : ~last_val;
    end
endmodule : sram_dev_model

// >>> sram_host.sv
// What this block does
// - A write spans the time chip select and write strobe are both low.
// - The address is valid no later than the last chip select assertion of a read.
// - With select and output drive held low, each address change brings the new word.
// - Data lines are shared; the host releases them whenever the memory may drive.
`timescale 1ns/1ps
module sram_host
    import sram_host_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    // Request side
    input  wire logic          req_valid,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    output logic               req_ready,
    output logic               rsp_valid,
    output logic      [DW-1:0] rsp_rdata,
    // Memory pins
    output logic      [AW-1:0] address_lines,
    output logic               chip_sel_n,
    output logic               write_strobe_n,
    output logic               out_drive_n,
    input  wire logic [DW-1:0] data_lines_in,
    output logic      [DW-1:0] data_lines_out,
    output logic               data_lines_oe
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        // Sequencer
        host_state_e       state;
        logic [CNT_W-1:0]  cnt;
        // Request side
        logic              ready;
        logic              rvalid;
        logic [DW-1:0]     rdata;
        // Memory pins
        logic [AW-1:0]     addr;
        logic              cs_n;
        logic              we_n;
        logic              oe_n;
        logic [DW-1:0]     dout;
        logic              doe;
    } host_s;

    host_s         st_reg;
    host_s         st_next;
    logic [DW-1:0] data_sync;
    req_s          req_in;
    pins_s         pins;

    // ------------------------------------------------------------------
    // Phase lengths
    // ------------------------------------------------------------------
    // Read: access time plus the three-stage sync delay
    localparam logic [CNT_W-1:0] READ_WAIT  = CNT_W'(READ_CYC + 3);
    // Write: strobe low time, address and data held throughout
    localparam logic [CNT_W-1:0] WRITE_WAIT = CNT_W'(WRITE_CYC);
    // Turnaround: memory outputs back to high impedance
    localparam logic [CNT_W-1:0] TURN_WAIT  = CNT_W'(TURN_CYC);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Count down, saturating at zero
    function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
        dec = (v == '0) ? '0 : CNT_W'(v - 1'b1);
    endfunction : dec

    // Phase over once the counter has run out
    function automatic logic phase_done(input logic [CNT_W-1:0] c);
        phase_done = (c == '0);
    endfunction : phase_done

    // All controls high: memory deselected and in standby
    function automatic host_s deselect(input host_s s);
        deselect      = s;
        deselect.cs_n = 1'b1;
        deselect.we_n = 1'b1;
        deselect.oe_n = 1'b1;
    endfunction : deselect

    // ------------------------------------------------------------------
    // Request carrier
    // ------------------------------------------------------------------
    // Request inputs gathered into one word
    assign req_in.valid = req_valid;
    assign req_in.write = req_write;
    assign req_in.addr  = req_addr;
    assign req_in.wdata = req_wdata;

    // ------------------------------------------------------------------
    // Data line input synchroniser
    // ------------------------------------------------------------------
    // Three flops and a holding register; a change counts once the last two flops agree
    sram_sync3 #(
        .WIDTH (DW)
    ) u_sync (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .async_in (data_lines_in),
        .sync_out (data_sync)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Defaults for each cycle, which the phases below can override: answer pulse cleared, counter runs down
    always_comb begin
        st_next        = st_reg;
        st_next.rvalid = 1'b0;
        st_next.cnt    = dec(st_reg.cnt);
        case (st_reg.state)
            // Idle: deselected, bus released, waiting for a request
            ST_IDLE: begin
                st_next     = deselect(st_next);
                st_next.doe = 1'b0;
                if (req_in.valid && st_reg.ready) begin
                    st_next.ready = 1'b0;
                    st_next.addr  = req_in.addr;
                    st_next.cs_n  = 1'b0;
                    if (req_in.write) begin
                        st_next.we_n  = 1'b0;
                        st_next.dout  = req_in.wdata;
                        st_next.doe   = 1'b1;
                        st_next.cnt   = WRITE_WAIT;
                        st_next.state = ST_WRITE;
                    end else begin
                        st_next.oe_n  = 1'b0;
                        st_next.cnt   = READ_WAIT;
                        st_next.state = ST_READ;
                    end
                end
            end
            // Read: selected with output drive low until the word has settled
            ST_READ: begin
                if (phase_done(st_reg.cnt)) begin
                    st_next        = deselect(st_next);
                    st_next.rdata  = data_sync;
                    st_next.rvalid = 1'b1;
                    st_next.cnt    = TURN_WAIT;
                    st_next.state  = ST_TURN;
                end
            end
            // Write: both strobes low, address and data held
            ST_WRITE: begin
                if (phase_done(st_reg.cnt)) begin
                    st_next       = deselect(st_next);
                    st_next.cnt   = TURN_WAIT;
                    st_next.state = ST_TURN;
                end
            end
            // Turnaround: host releases the lines before the next request
            ST_TURN: begin
                st_next.doe = 1'b0;
                if (phase_done(st_reg.cnt)) begin
                    st_next.ready = 1'b1;
                    st_next.state = ST_IDLE;
                end
            end
            // Unused codes fall back to idle
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg       <= '0;
            st_reg.state <= ST_IDLE;
            st_reg.ready <= 1'b1;
            st_reg.cs_n  <= 1'b1;
            st_reg.we_n  <= 1'b1;
            st_reg.oe_n  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Pin carrier
    // ------------------------------------------------------------------
    // Memory pin set taken straight from the state register
    assign pins.address_lines  = st_reg.addr;
    assign pins.chip_sel_n     = st_reg.cs_n;
    assign pins.write_strobe_n = st_reg.we_n;
    assign pins.out_drive_n    = st_reg.oe_n;
    assign pins.data_out       = st_reg.dout;
    assign pins.data_oe        = st_reg.doe;

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Request side straight from flip-flops
    assign req_ready      = st_reg.ready;
    assign rsp_valid      = st_reg.rvalid;
    assign rsp_rdata      = st_reg.rdata;

    // Memory pins from the carrier, no logic in between
    assign address_lines  = pins.address_lines;
    assign chip_sel_n     = pins.chip_sel_n;
    assign write_strobe_n = pins.write_strobe_n;
    assign out_drive_n    = pins.out_drive_n;
    assign data_lines_out = pins.data_out;
    assign data_lines_oe  = pins.data_oe;

endmodule : sram_host

// >>> sram_host_chk.sv
`timescale 1ns/1ps
module sram_host_chk
    import sram_host_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              sys_rst,
    input wire logic              req_valid,
    input wire logic              req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic              req_ready,
    input wire logic              rsp_valid,
    input wire logic [ADDR_W-1:0] address_lines,
    input wire logic              chip_sel_n,
    input wire logic              write_strobe_n,
    input wire logic              out_drive_n,
    input wire logic [DATA_W-1:0] data_lines_out,
    input wire logic              data_lines_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic rd_go;
    logic wr_go;
    // ------------------------------------------------------------
    // Pin relations
    // ------------------------------------------------------------
    assign rd_go = req_valid && req_ready && !req_write;
    assign wr_go = req_valid && req_ready && req_write;
    property p_wr_pins; wr_go |=> !chip_sel_n && !write_strobe_n
        && address_lines == $past(req_addr) && data_lines_out == $past(req_wdata); endproperty
    a_wr_pins: assert property (p_wr_pins) else $error("write pins wrong");
    property p_rd_pins; rd_go |=> !chip_sel_n && write_strobe_n && !out_drive_n
        && address_lines == $past(req_addr); endproperty
    a_rd_pins: assert property (p_rd_pins) else $error("read pins wrong");
    property p_rd_rsp; rd_go |-> ##[6:7] rsp_valid; endproperty
    a_rd_rsp: assert property (p_rd_rsp) else $error("read answer late");
    property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer too long");
    property p_wr_end; $rose(write_strobe_n) |-> $rose(chip_sel_n); endproperty
    a_wr_end: assert property (p_wr_end) else $error("write end split");
    property p_release; !chip_sel_n && write_strobe_n |-> !data_lines_oe; endproperty
    a_release: assert property (p_release) else $error("bus not released");
    property p_wr_oe; !chip_sel_n && !write_strobe_n |-> data_lines_oe; endproperty
    a_wr_oe: assert property (p_wr_oe) else $error("write data not driven");
    property p_addr_hold; !chip_sel_n && !$past(chip_sel_n) |-> $stable(address_lines);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
endmodule : sram_host_chk

bind sram_host sram_host_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .address_lines(address_lines), .chip_sel_n(chip_sel_n),
    .write_strobe_n(write_strobe_n), .out_drive_n(out_drive_n),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));

// >>> sram_host_pkg.sv
package sram_host_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 18;
    localparam int DATA_W     = 4;
    localparam int WORD_COUNT = 262144;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 20;
    localparam int READ_ACCESS_NS = 35;  // Slowest grade address/select access
    localparam int WRITE_PULSE_NS = 20;  // Slowest grade strobe width
    localparam int TURN_NS        = 15;  // Slowest grade release to high-Z
    localparam int READ_CYC  = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC  = (TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W     = 4;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_s;

    typedef struct packed {
        logic [ADDR_W-1:0] address_lines;
        logic              chip_sel_n;
        logic              write_strobe_n;
        logic              out_drive_n;
        logic [DATA_W-1:0] data_out;
        logic              data_oe;
    } pins_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_READ  = 3'b001,
        ST_WRITE = 3'b010,
        ST_TURN  = 3'b011
    } host_state_e;

endpackage : sram_host_pkg

// >>> sram_sync3.sv
`timescale 1ns/1ps
module sram_sync3
    import sram_host_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] held;
    } sync_s;

    sync_s st_reg;
    sync_s st_next;

    // Shift chain; a value counts once stages two and three agree
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.held = st_reg.s3;
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.held;

endmodule : sram_sync3

// >>> tb_sram_host.sv
`timescale 1ns/1ps
module tb_sram_host;
    import sram_host_pkg::*;
    logic clk_sys = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0, address_lines;
    logic [DATA_W-1:0] req_wdata = '0, dq_wire, mem_dout, data_lines_out, rsp_rdata;
    logic req_ready, rsp_valid, chip_sel_n, write_strobe_n, out_drive_n, data_lines_oe;
    int miscompares = 0, comparisons = 0;
    assign dq_wire = data_lines_oe ? data_lines_out : mem_dout;
    initial forever #10 clk_sys = ~clk_sys;
    sram_host DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .address_lines(address_lines), .chip_sel_n(chip_sel_n),
        .write_strobe_n(write_strobe_n), .out_drive_n(out_drive_n),
        .data_lines_in(dq_wire), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe));
    sram_dev_model mem (.address_lines(address_lines), .chip_sel_n(chip_sel_n),
        .write_strobe_n(write_strobe_n), .out_drive_n(out_drive_n),
        .data_in(dq_wire), .data_out(mem_dout));
    task automatic check(input string what, input logic [DATA_W-1:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // One request, waited out under a bound; reads compared
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(negedge clk_sys);
        req_valid = 1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge clk_sys);
        req_valid = 0;
        n = 0;
        while (!(wr ? req_ready === 1'b1 : rsp_valid === 1'b1) && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        if (!wr) check("read word", d, rsp_rdata);
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 50) begin
            miscompares++;
            $display("[ERR] wait cycles expected %0d seen %0d", 49, n);
            stop_test();
        end
    endtask : xfer
    // Idle pins after reset: deselected, released
    task automatic t_reset;
        check("idle pins", 4'he, {chip_sel_n, write_strobe_n, out_drive_n, data_lines_oe});
        check("ready", 4'h1, {3'h0, req_ready});
    endtask : t_reset
    // Address extremes and single-bit addresses
    task automatic t_corners;
        logic [ADDR_W-1:0] adr [4] = '{18'h00000, 18'h3ffff, 18'h20000, 18'h00001};
        for (int i = 0; i < 4; i++) xfer(1'b1, adr[i], 4'h3 + 4'(i * 5));
        for (int i = 0; i < 4; i++) xfer(1'b0, adr[i], 4'h3 + 4'(i * 5));
    endtask : t_corners
    // Overwrite then back-to-back reads of neighbours
    task automatic t_overwrite;
        xfer(1'b1, 18'h00005, 4'ha);
        xfer(1'b1, 18'h00005, 4'h5);
        xfer(1'b1, 18'h00006, 4'hf);
        xfer(1'b0, 18'h00005, 4'h5);
        xfer(1'b0, 18'h00006, 4'hf);
        check("pins after read", 4'he, {chip_sel_n, write_strobe_n, out_drive_n, data_lines_oe});
    endtask : t_overwrite
    initial begin
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 0;
        t_reset();
        t_corners();
        t_overwrite();
        stop_test();
    end
endmodule : tb_sram_host
